// ---- hw/irq_regs_map.svh ----
// Register offsets, field positions and reset values of the interrupt registers
`ifndef IRQ_REGS_MAP_SVH
`define IRQ_REGS_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ENABLE_TWO_OFS 8'h00
`define REQUEST_ONE_OFS 8'h04
`define MASTER_CTRL_OFS 8'h08
`define IRQ_STATUS_OFS 8'h0C
`define IRQ_MASK_OFS 8'h10

// ****************************************************************
// Enable two field positions
// ****************************************************************
`define OSC_FAIL_IRQ_EN_BIT 7
`define COMPARATOR_B_IRQ_EN_BIT 6
`define COMPARATOR_A_IRQ_EN_BIT 5
`define EEPROM_WRITE_IRQ_EN_BIT 4
`define BUS_COLLISION_IRQ_EN_BIT 3
`define LOW_POWER_WAKE_IRQ_EN_BIT 2
`define CAPCMP_B_IRQ_EN_BIT 0
`define ENABLE_TWO_IMPL_MASK 8'hFD

// ****************************************************************
// Request one field positions
// ****************************************************************
`define CONVERTER_DONE_FLAG_BIT 6
`define SERIAL_RX_FULL_FLAG_BIT 5
`define SERIAL_TX_EMPTY_FLAG_BIT 4
`define SYNC_SERIAL_FLAG_BIT 3
`define CAPCMP_A_FLAG_BIT 2
`define TIMER_B_MATCH_FLAG_BIT 1
`define TIMER_A_OVERFLOW_FLAG_BIT 0
`define REQUEST_ONE_IMPL_MASK 8'h7F
`define REQUEST_ONE_SW_MASK 8'h4F

// ****************************************************************
// Master control and interrupt status fields
// ****************************************************************
`define GLOBAL_IRQ_EN_BIT 0
`define PERIPHERAL_MASTER_IRQ_EN_BIT 1
`define MASTER_CTRL_IMPL_MASK 8'h03
`define STATUS_PERIPH_REQ_BIT 7

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define REG_RESET_VALUE 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hw/irq_regs_pkg.sv ----
// Types shared by the interrupt register block
`default_nettype none

package irq_regs_pkg;

    // Write request from the bus front end
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_t;

    // Read answer from the register decode
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } rd_ans_t;

    // Master enables
    typedef struct packed {
        logic peripheral_master_irq_en;
        logic global_irq_en;
    } master_ctrl_t;

endpackage : irq_regs_pkg

`default_nettype wire

// ---- hw/irq_flag_bits.sv ----
// Vector of flag bits with hardware set winning over software write or clear
`default_nettype none

module irq_flag_bits #(
    parameter int WIDTH = 8,
    parameter bit W1C = 1'b0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Set and software access
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] wr_mask,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    // State
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    // Next value: write or clear, then hardware set on top
    always_comb
    begin
        q_next = q_reg;
        if (wr_en)
        begin
            if (W1C)
                q_next = q_reg & ~(wr_data & wr_mask);
            else
                q_next = (q_reg & ~wr_mask) | (wr_data & wr_mask);
        end
        q_next = q_next | set;
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q_reg <= '0;
        else
            q_reg <= q_next;
    end

    assign q = q_reg;

endmodule : irq_flag_bits

`default_nettype wire

// ---- hw/axil_front.sv ----
// AXI4-Lite slave handshake front end
`default_nettype none

module axil_front (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // Write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // Read address and data
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Register side
    output irq_regs_pkg::wr_req_t wr_req,
    input wire logic [1:0] wr_resp,
    input wire irq_regs_pkg::rd_ans_t rd_ans
);

    logic aw_held_reg, aw_held_next;
    logic w_held_reg, w_held_next;
    logic [7:0] addr_reg, addr_next;
    logic [31:0] data_reg, data_next;
    logic [3:0] strb_reg, strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    irq_regs_pkg::rd_ans_t rans_reg, rans_next;
    logic do_write;

    // Ready while nothing is held and no answer waits
    assign s_awready = !aw_held_reg && !bvalid_reg;
    assign s_wready = !w_held_reg && !bvalid_reg;
    assign s_arready = !rvalid_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    // Next values of both channels
    always_comb
    begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        strb_next = strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rans_next = rans_reg;
        if (s_awvalid && s_awready)
        begin
            aw_held_next = 1'b1;
            addr_next = s_awaddr;
        end
        if (s_wvalid && s_wready)
        begin
            w_held_next = 1'b1;
            data_next = s_wdata;
            strb_next = s_wstrb;
        end
        if (do_write)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_resp;
        end
        else if (bvalid_reg && s_bready)
            bvalid_next = 1'b0;
        if (s_arvalid && s_arready)
        begin
            rvalid_next = 1'b1;
            rans_next = rd_ans;
        end
        else if (rvalid_reg && s_rready)
            rvalid_next = 1'b0;
    end

    // Channel registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            addr_reg <= 8'h00;
            data_reg <= 32'h00000000;
            strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rvalid_reg <= 1'b0;
            rans_reg <= '0;
        end
        else
        begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            strb_reg <= strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rans_reg <= rans_next;
        end
    end

    assign wr_req = '{valid: do_write, addr: addr_reg, data: data_reg, strb: strb_reg};
    assign s_bvalid = bvalid_reg;
    assign s_bresp = bresp_reg;
    assign s_rvalid = rvalid_reg;
    assign s_rdata = rans_reg.data;
    assign s_rresp = rans_reg.resp;

endmodule : axil_front

`default_nettype wire

// ---- hw/peripheral_irq_regs.sv ----
// Peripheral interrupt enable and request registers with AXI4-Lite access
// ****************************************************************
// Behaviour
// [RL1] Enable two bit 7 gates the oscillator-failure interrupt.
// [RL2] Enable two bits 6 and 5 gate comparator b and a interrupts.
// [RL3] Enable two bit 4 gates the EEPROM write-complete interrupt.
// [RL4] Enable two bit 3 gates the bus-collision interrupt.
// [RL5] Enable two bit 2 gates the low-power wake-up interrupt.
// [RL6] Enable two bit 0 gates the second capture/compare interrupt.
// [RL7] Enable two bit 1 and request one bit 7 read zero, ignore writes.
// [RL8] Flags set on their event regardless of any enable.
// [RL9] Software should clear a flag before setting its enable.
// [RL10] Receive and transmit flags read-only; other request one flags writable.
// [RL11] Receive flag follows buffer full; transmit flag follows buffer empty.
// [RL12] Software clears timer, capture, converter and serial port flags itself.
// [RL13] No peripheral request passes unless the peripheral master enable is set. Here irq still follows flag edges through the status register without it.
// [RL14] Request is any flag with its enable, gated by both master enables.
// ****************************************************************
`default_nettype none
`include "irq_regs_map.svh"

module peripheral_irq_regs (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // AXI4-Lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    // AXI4-Lite read data
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Peripheral events, one-cycle pulses
    input wire logic converter_done_evt,
    input wire logic sync_serial_evt,
    input wire logic capcmp_a_evt,
    input wire logic timer_b_match_evt,
    input wire logic timer_a_overflow_evt,
    // Serial buffer levels
    input wire logic rx_buffer_full,
    input wire logic tx_buffer_empty,
    // Neighbouring enable and request registers
    input wire logic [7:0] enable_one_in,
    input wire logic [7:0] request_two_in,
    // Register views
    output logic [7:0] peripheral_irq_enable_two,
    output logic [7:0] peripheral_irq_request_one,
    // Interrupt requests
    output logic periph_irq_req,
    output logic cpu_irq_req,
    output logic irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    irq_regs_pkg::wr_req_t wr_req;
    irq_regs_pkg::rd_ans_t rd_ans;
    irq_regs_pkg::master_ctrl_t ctrl_reg;
    irq_regs_pkg::master_ctrl_t ctrl_next;
    logic [1:0] wr_resp;
    logic [7:0] enable_two_reg;
    logic [7:0] enable_two_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] flags_q;
    logic [7:0] flag_set;
    logic [7:0] request_one;
    logic [7:0] prev_request_reg;
    logic [7:0] prev_request_next;
    logic prev_periph_reg;
    logic prev_periph_next;
    logic [7:0] status_q;
    logic [7:0] status_set;
    logic wr_lane0;
    logic wr_enable_two;
    logic wr_request_one;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic pending_one;
    logic pending_two;
    logic periph_req;

    // ****************************************************************
    // Bus front end
    // ****************************************************************

    // AXI4-Lite handshakes and answer registers
    axil_front u_front (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr_req(wr_req),
        .wr_resp(wr_resp),
        .rd_ans(rd_ans)
    );

    // ****************************************************************
    // Write decode
    // ****************************************************************

    // Data sits in byte lane 0 only
    assign wr_lane0 = wr_req.valid && wr_req.strb[0];

    // Address decode of a write
    always_comb
    begin
        wr_enable_two = 1'b0;
        wr_request_one = 1'b0;
        wr_ctrl = 1'b0;
        wr_status = 1'b0;
        wr_mask = 1'b0;
        wr_resp = `RESP_OKAY;
        if (wr_req.addr == `ENABLE_TWO_OFS)
            wr_enable_two = wr_lane0;
        else if (wr_req.addr == `REQUEST_ONE_OFS)
            wr_request_one = wr_lane0;
        else if (wr_req.addr == `MASTER_CTRL_OFS)
            wr_ctrl = wr_lane0;
        else if (wr_req.addr == `IRQ_STATUS_OFS)
            wr_status = wr_lane0;
        else if (wr_req.addr == `IRQ_MASK_OFS)
            wr_mask = wr_lane0;
        else
            wr_resp = `RESP_SLVERR;
    end

    // ****************************************************************
    // Enable two, master control and mask
    // ****************************************************************

    // Next values of software-owned registers
    always_comb
    begin
        enable_two_next = enable_two_reg;
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        if (wr_enable_two)
            enable_two_next = wr_req.data[7:0] & `ENABLE_TWO_IMPL_MASK; // RL7
        if (wr_ctrl)
        begin
            ctrl_next.global_irq_en = wr_req.data[`GLOBAL_IRQ_EN_BIT];
            ctrl_next.peripheral_master_irq_en =
                wr_req.data[`PERIPHERAL_MASTER_IRQ_EN_BIT];
        end
        if (wr_mask)
            mask_next = wr_req.data[7:0];
    end

    // Software-owned registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_two_reg <= `REG_RESET_VALUE;
            ctrl_reg <= '0;
            mask_reg <= `REG_RESET_VALUE;
        end
        else
        begin
            enable_two_reg <= enable_two_next;
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
        end
    end

    // ****************************************************************
    // Request one flags
    // ****************************************************************

    // Events set flags whatever the enables say
    always_comb
    begin
        flag_set = 8'h00; // RL8
        flag_set[`CONVERTER_DONE_FLAG_BIT] = converter_done_evt;
        flag_set[`SYNC_SERIAL_FLAG_BIT] = sync_serial_evt;
        flag_set[`CAPCMP_A_FLAG_BIT] = capcmp_a_evt;
        flag_set[`TIMER_B_MATCH_FLAG_BIT] = timer_b_match_evt;
        flag_set[`TIMER_A_OVERFLOW_FLAG_BIT] = timer_a_overflow_evt;
    end

    // Sticky flags, cleared only by software
    irq_flag_bits #(
        .WIDTH(8),
        .W1C(1'b0)
    ) u_request_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(flag_set),
        .wr_mask(`REQUEST_ONE_SW_MASK), // RL10
        .wr_en(wr_request_one),
        .wr_data(wr_req.data[7:0]),
        .q(flags_q)
    );

    // Serial flags mirror the buffer levels
    always_comb
    begin
        request_one = flags_q & `REQUEST_ONE_SW_MASK; // RL7
        request_one[`SERIAL_RX_FULL_FLAG_BIT] = rx_buffer_full; // RL11
        request_one[`SERIAL_TX_EMPTY_FLAG_BIT] = tx_buffer_empty; // RL11
    end

    // ****************************************************************
    // Request combination
    // ****************************************************************

    // Flags paired with their enables
    assign pending_one = |(request_one & enable_one_in);
    assign pending_two = |(request_two_in & enable_two_reg); // RL1 RL2 RL3 RL4 RL5 RL6

    // Peripheral request needs the peripheral master enable
    assign periph_req = (pending_one || pending_two)
        && ctrl_reg.peripheral_master_irq_en; // RL13 RL14

    // ****************************************************************
    // Event status and interrupt output
    // ****************************************************************

    // Rising edges of flags and of the peripheral request
    always_comb
    begin
        status_set = request_one & ~prev_request_reg;
        status_set[`STATUS_PERIPH_REQ_BIT] = periph_req && !prev_periph_reg;
        prev_request_next = request_one;
        prev_periph_next = periph_req;
    end

    // Previous values for edge detection
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prev_request_reg <= 8'h00;
            prev_periph_reg <= 1'b0;
        end
        else
        begin
            prev_request_reg <= prev_request_next;
            prev_periph_reg <= prev_periph_next;
        end
    end

    // Sticky status, write one to clear, set wins
    irq_flag_bits #(
        .WIDTH(8),
        .W1C(1'b1)
    ) u_status (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(status_set),
        .wr_mask(8'hFF),
        .wr_en(wr_status),
        .wr_data(wr_req.data[7:0]),
        .q(status_q)
    );

    // ****************************************************************
    // Read decode
    // ****************************************************************

    // Answer for the read address now on the bus
    always_comb
    begin
        rd_ans.data = 32'h00000000;
        rd_ans.resp = `RESP_OKAY;
        if (s_araddr == `ENABLE_TWO_OFS)
            rd_ans.data[7:0] = enable_two_reg;
        else if (s_araddr == `REQUEST_ONE_OFS)
            rd_ans.data[7:0] = request_one;
        else if (s_araddr == `MASTER_CTRL_OFS)
            rd_ans.data[1:0] = ctrl_reg;
        else if (s_araddr == `IRQ_STATUS_OFS)
            rd_ans.data[7:0] = status_q;
        else if (s_araddr == `IRQ_MASK_OFS)
            rd_ans.data[7:0] = mask_reg;
        else
            rd_ans.resp = `RESP_SLVERR;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Register views, with the serial flags taken straight from the buffer levels, and request lines
    assign peripheral_irq_enable_two = enable_two_reg;
    assign peripheral_irq_request_one = request_one;
    assign periph_irq_req = periph_req;
    assign cpu_irq_req = periph_req && ctrl_reg.global_irq_en; // RL14
    assign irq = |(status_q & mask_reg);

endmodule : peripheral_irq_regs

`default_nettype wire

// ---- testbench/irq_regs_props.sv ----
// Concurrent checks on the peripheral interrupt register ports
`default_nettype none

module irq_regs_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus answer
    input wire logic s_bvalid,
    input wire logic [1:0] s_bresp,
    // Events and levels
    input wire logic converter_done_evt,
    input wire logic sync_serial_evt,
    input wire logic capcmp_a_evt,
    input wire logic timer_b_match_evt,
    input wire logic timer_a_overflow_evt,
    input wire logic rx_buffer_full,
    input wire logic tx_buffer_empty,
    input wire logic [7:0] enable_one_in,
    input wire logic [7:0] request_two_in,
    // Register views and requests
    input wire logic [7:0] peripheral_irq_enable_two,
    input wire logic [7:0] peripheral_irq_request_one,
    input wire logic periph_irq_req,
    input wire logic cpu_irq_req,
    input wire logic irq
);
    logic [7:0] evt_v;

    // Events placed at their flag positions
    assign evt_v = {1'b0, converter_done_evt, 2'b00, sync_serial_evt, capcmp_a_evt,
        timer_b_match_evt, timer_a_overflow_evt};

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ********************
    // Assertions
    // ********************
    a_rx_flag_live: assert property (peripheral_irq_request_one[5] == rx_buffer_full)
        else $error("receive flag differs from buffer level");
    a_tx_flag_live: assert property (peripheral_irq_request_one[4] == tx_buffer_empty)
        else $error("transmit flag differs from buffer level");
    a_unimpl_zero: assert property (!peripheral_irq_enable_two[1] && !peripheral_irq_request_one[7])
        else $error("unimplemented bit reads one");
    a_event_sets: assert property (evt_v != 8'h00 |=>
        (peripheral_irq_request_one & $past(evt_v)) == $past(evt_v))
        else $error("event did not set its flag");
    a_periph_cause: assert property (periph_irq_req |->
        ((peripheral_irq_request_one & enable_one_in) != 8'h00)
        || ((peripheral_irq_enable_two & request_two_in) != 8'h00))
        else $error("peripheral request without enabled flag");
    a_cpu_needs_periph: assert property (cpu_irq_req |-> periph_irq_req)
        else $error("processor request without peripheral request");
    a_enable_by_write: assert property ($changed(peripheral_irq_enable_two) |-> $rose(s_bvalid))
        else $error("enable register changed without a write");
    a_flag_kept: assert property ($fell(peripheral_irq_request_one[6]) |-> $rose(s_bvalid))
        else $error("converter flag cleared by hardware");

    // Main scenarios reached
    c_cpu_req: cover property (cpu_irq_req);
    c_irq: cover property (irq);
    c_slverr: cover property ($rose(s_bvalid) && s_bresp == 2'h2);
endmodule : irq_regs_props

`default_nettype wire

// ---- testbench/tb_peripheral_irq_regs.sv ----
// Self-checking bench for the peripheral interrupt registers
`default_nettype none
`include "irq_regs_map.svh"

module tb_peripheral_irq_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic periph_irq_req, cpu_irq_req, irq, rx_buffer_full, tx_buffer_empty;
    logic [7:0] s_awaddr, s_araddr, enable_one_in, request_two_in;
    logic [7:0] peripheral_irq_enable_two, peripheral_irq_request_one;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    logic [4:0] ev;
    int n_errors = 0;
    int samples_checked = 0;

    peripheral_irq_regs dut (
        .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
        .converter_done_evt(ev[4]), .sync_serial_evt(ev[3]), .capcmp_a_evt(ev[2]),
        .timer_b_match_evt(ev[1]), .timer_a_overflow_evt(ev[0]),
        .rx_buffer_full, .tx_buffer_empty, .enable_one_in, .request_two_in,
        .peripheral_irq_enable_two, .peripheral_irq_request_one,
        .periph_irq_req, .cpu_irq_req, .irq
    );

    // Clock generator
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // ********************
    // Tasks
    // ********************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= {24'h000000, d};
        s_wstrb <= s;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge aclk);
            ta = s_awvalid && s_awready;
            tw = s_wvalid && s_wready;
            tb = s_bvalid;
            r = s_bresp;
            @(posedge aclk);
            if (ta)
                s_awvalid <= 1'b0;
            if (tw)
                s_wvalid <= 1'b0;
        end
        s_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge aclk);
            ta = s_arvalid && s_arready;
            tr = s_rvalid;
            d = s_rdata;
            r = s_rresp;
            @(posedge aclk);
            if (ta)
                s_arvalid <= 1'b0;
        end
        s_rready <= 1'b0;
        chk("rdata", {24'h0, e}, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rd

    task automatic pin(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : pin

    task automatic pulse(input logic [4:0] v);
        @(posedge aclk);
        ev <= v;
        @(posedge aclk);
        ev <= 5'h00;
        repeat (3) @(negedge aclk);
    endtask : pulse

    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        summarize();
    end

    // ********************
    // Test sequence
    // ********************
    initial
    begin
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h00;
        {rx_buffer_full, tx_buffer_empty, ev, s_wstrb} = 11'h000;
        {s_awaddr, s_araddr, enable_one_in, request_two_in} = 32'h0;
        s_wdata = 32'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ENABLE_TWO_OFS, 8'h00, `RESP_OKAY);
        rd(`REQUEST_ONE_OFS, 8'h00, `RESP_OKAY);
        $display("test reset done");
        wr(`REQUEST_ONE_OFS, 8'hFF, 4'hF, `RESP_OKAY);
        rd(`REQUEST_ONE_OFS, 8'h4F, `RESP_OKAY);
        wr(`REQUEST_ONE_OFS, 8'h00, 4'hF, `RESP_OKAY);
        @(posedge aclk);
        {rx_buffer_full, tx_buffer_empty} <= 2'b11;
        wr(`REQUEST_ONE_OFS, 8'h00, 4'hF, `RESP_OKAY);
        rd(`REQUEST_ONE_OFS, 8'h30, `RESP_OKAY);
        @(posedge aclk);
        {rx_buffer_full, tx_buffer_empty} <= 2'b00;
        rd(`REQUEST_ONE_OFS, 8'h00, `RESP_OKAY);
        $display("test software flags done");
        enable_one_in <= 8'h01;
        pulse(5'h1F);
        pin("periph_irq_req", 1'b0, periph_irq_req);
        rd(`REQUEST_ONE_OFS, 8'h4F, `RESP_OKAY);
        wr(`MASTER_CTRL_OFS, 8'h01, 4'hF, `RESP_OKAY);
        pin("periph_irq_req", 1'b0, periph_irq_req);
        wr(`MASTER_CTRL_OFS, 8'h02, 4'hF, `RESP_OKAY);
        pin("periph_irq_req", 1'b1, periph_irq_req);
        pin("cpu_irq_req", 1'b0, cpu_irq_req);
        wr(`MASTER_CTRL_OFS, 8'h03, 4'hF, `RESP_OKAY);
        pin("cpu_irq_req", 1'b1, cpu_irq_req);
        wr(`REQUEST_ONE_OFS, 8'h00, 4'hF, `RESP_OKAY);
        pin("periph_irq_req", 1'b0, periph_irq_req);
        $display("test events and masters done");
        request_two_in <= 8'hFF;
        for (int i = 0; i < 8; i++)
        begin
            wr(`ENABLE_TWO_OFS, 8'h01 << i, 4'hF, `RESP_OKAY);
            rd(`ENABLE_TWO_OFS, (i == 1) ? 8'h00 : 8'h01 << i, `RESP_OKAY);
            pin("periph_irq_req", i != 1, periph_irq_req);
        end
        wr(`ENABLE_TWO_OFS, 8'h5A, 4'h0, `RESP_OKAY);
        rd(`ENABLE_TWO_OFS, 8'h80, `RESP_OKAY);
        wr(`ENABLE_TWO_OFS, 8'h00, 4'hF, `RESP_OKAY);
        request_two_in <= 8'h00;
        $display("test enable gating done");
        wr(`IRQ_MASK_OFS, 8'h00, 4'hF, `RESP_OKAY);
        wr(`IRQ_STATUS_OFS, 8'hFF, 4'hF, `RESP_OKAY);
        pulse(5'h01);
        pin("irq", 1'b0, irq);
        rd(`IRQ_STATUS_OFS, 8'h81, `RESP_OKAY);
        wr(`IRQ_MASK_OFS, 8'h01, 4'hF, `RESP_OKAY);
        pin("irq", 1'b1, irq);
        wr(`IRQ_STATUS_OFS, 8'h01, 4'hF, `RESP_OKAY);
        pin("irq", 1'b0, irq);
        rd(`IRQ_STATUS_OFS, 8'h80, `RESP_OKAY);
        $display("test interrupt line done");
        wr(8'h14, 8'hFF, 4'hF, `RESP_SLVERR);
        rd(8'h14, 8'h00, `RESP_SLVERR);
        rd(8'h01, 8'h00, `RESP_SLVERR);
        $display("test unmapped done");
        summarize();
    end
endmodule : tb_peripheral_irq_regs

bind peripheral_irq_regs irq_regs_props props (
    .aclk, .aresetn, .s_bvalid, .s_bresp, .converter_done_evt, .sync_serial_evt,
    .capcmp_a_evt, .timer_b_match_evt, .timer_a_overflow_evt, .rx_buffer_full,
    .tx_buffer_empty, .enable_one_in, .request_two_in, .peripheral_irq_enable_two,
    .peripheral_irq_request_one, .periph_irq_req, .cpu_irq_req, .irq
);

`default_nettype wire
